// *** emu_map_pkg.sv ***
package emu_map_pkg;
  // Register byte offsets
  localparam logic [11:0] ctrl_off      = 12'h000;
  localparam logic [11:0] status_off    = 12'h004;
  localparam logic [11:0] irq_stat_off  = 12'h008;
  localparam logic [11:0] irq_mask_off  = 12'h00c;
  localparam logic [11:0] step_off      = 12'h010;
  localparam logic [11:0] bkpt_addr_off = 12'h014;
  localparam logic [11:0] bkpt_cmd_off  = 12'h018;
  localparam logic [11:0] fault_off     = 12'h01c;
  localparam logic [11:0] range_base    = 12'h040;
  // Control register fields
  localparam int ctrl_rom_brk_bit  = 0;
  localparam int ctrl_trig_brk_bit = 1;
  localparam int ctrl_wait_bit     = 2;
  localparam int ctrl_show_bg_bit  = 3;
  localparam int ctrl_reset_bit    = 4;
  localparam int ctrl_tclk_bit     = 5;
  localparam int ctrl_bg_bit       = 6;
  localparam logic [6:0] ctrl_reset_val = 7'h40;
  // Interrupt status bits
  localparam int ev_guard  = 0;
  localparam int ev_rom    = 1;
  localparam int ev_trig   = 2;
  localparam int ev_bkpt   = 3;
  localparam int ev_step   = 4;
  localparam int ev_width  = 5;
  // Range entry: base at +0, limit at +4, attribute at +8, stride 16 bytes
  localparam int range_stride_lg = 4;
  localparam int range_count     = 16;
  localparam int page_lsb        = 8;
  localparam logic [7:0] bkpt_opcode = 8'hf1;
  localparam int monitor_bytes   = 4096;
  localparam int osc_mhz_int     = 16;
  localparam int tclk_min_mhz    = 2;
  localparam int tclk_max_mhz    = 16;

  typedef enum logic [2:0] {
    attr_none   = 3'b000,
    attr_emu_ram = 3'b001,
    attr_emu_rom = 3'b010,
    attr_tgt_ram = 3'b011,
    attr_tgt_rom = 3'b100,
    attr_guard   = 3'b101
  } attr_t;

  typedef enum logic [1:0] {
    run_bg   = 2'b00,
    run_fg   = 2'b01,
    run_step = 2'b10
  } run_t;
endpackage : emu_map_pkg

// *** range_table.sv ***
`timescale 1ns/1ps
// Sixteen-entry range store with parallel match; lookup result is registered
module range_table #(
  parameter int  entries = 16,
  parameter int  aw      = 24
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [3:0]        wr_idx,
  input  wire logic [1:0]        wr_fld,
  input  wire logic [31:0]       wr_data,
  // Read port
  input  wire logic [3:0]        rd_idx,
  input  wire logic [1:0]        rd_fld,
  output logic      [31:0]       rd_data,
  // Lookup
  input  wire logic [aw-1:0]     look_addr,
  output emu_map_pkg::attr_t     look_attr
);
  localparam int pw = aw - emu_map_pkg::page_lsb;

  logic [pw-1:0]       base_q  [entries];
  logic [pw-1:0]       limit_q [entries];
  emu_map_pkg::attr_t  attr_q  [entries];
  logic [entries-1:0]  hit;

  // Entry storage, page granular so low byte bits are never compared
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < entries; i++)
      begin
        base_q[i]  <= '0;
        limit_q[i] <= '0;
        attr_q[i]  <= emu_map_pkg::attr_none;
      end
    end
    else if (wr_en)
    begin
      case (wr_fld)
        2'h0: base_q[wr_idx]  <= wr_data[aw-1:emu_map_pkg::page_lsb];
        2'h1: limit_q[wr_idx] <= wr_data[aw-1:emu_map_pkg::page_lsb];
        2'h2: attr_q[wr_idx]  <= emu_map_pkg::attr_t'(wr_data[2:0]);
        default: ;
      endcase
    end
  end

  // Per-entry compare on pages; limit is the last page, so length is at least 256
  for (genvar g = 0; g < entries; g++)
  begin : g_cmp
    assign hit[g] = (attr_q[g] != emu_map_pkg::attr_none) &&
                    (look_addr[aw-1:emu_map_pkg::page_lsb] >= base_q[g]) &&
                    (look_addr[aw-1:emu_map_pkg::page_lsb] <= limit_q[g]);
  end

  // Lowest index wins on overlap; no hit means target memory
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      look_attr <= emu_map_pkg::attr_tgt_ram;
    else
    begin
      look_attr <= emu_map_pkg::attr_tgt_ram;
      for (int i = entries - 1; i >= 0; i--)
        if (hit[i])
          look_attr <= attr_q[i];
    end
  end

  // Registered read-back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_data <= '0;
    else
    begin
      case (rd_fld)
        2'h0: rd_data <= 32'({base_q[rd_idx], 8'h00});
        2'h1: rd_data <= 32'({limit_q[rd_idx], 8'hff});
        2'h2: rd_data <= {29'h0, attr_q[rd_idx]};
        default: rd_data <= '0;
      endcase
    end
  end
endmodule : range_table

// *** emu_map_ctrl.sv ***
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Operation
// - Up to sixteen address ranges are each defined and attributed on their own.
// - Ranges are 256-byte aligned and at least 256 bytes long, compared above bit 7.
// - Each range has one of emulation RAM, emulation ROM, target RAM, target ROM, guarded.
// - An access to a guarded range raises an error flag.
// - With the option on, a write to a ROM range breaks to the monitor.
// - The monitor takes 4K bytes of emulation memory, leaving the rest for ranges.
// - An analyzer trigger forces a break into the background monitor.
// - Setting a software breakpoint saves the byte and writes opcode F1, whose fetch breaks.
// - The processor resets on controller command or on target reset.
// - A setting chooses whether background cycles are shown to the target.
// - On request, run one or a counted number of instructions, then return to the monitor.
// - The processor clock is the internal 16 MHz oscillator or the 2-16 MHz target clock.
module emu_map_ctrl #(
  parameter int aw        = 24,
  parameter int emu_bytes = 131072
) (
  // APB slave
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Processor bus
  input  wire logic          cpu_valid,
  input  wire logic          cpu_write,
  input  wire logic          cpu_fetch,
  input  wire logic          cpu_done,
  input  wire logic [aw-1:0] cpu_addr,
  input  wire logic [7:0]    cpu_rdata,
  output logic               cpu_stall,
  output logic               cpu_break,
  output logic               cpu_reset,
  output logic               clk_sel_target,
  // Breakpoint patch port to memory
  output logic               patch_we,
  output logic [aw-1:0]      patch_addr,
  output logic [7:0]         patch_data,
  // Target interface
  input  wire logic          tgt_wait,
  input  wire logic          tgt_reset,
  output logic               tgt_cycle,
  output logic               emu_sel,
  output logic               rom_sel,
  // Analyzer and interrupt
  input  wire logic          trig_in,
  output logic               irq
);
  typedef enum logic [1:0] {
    bk_idle  = 2'b00,
    bk_read  = 2'b01,
    bk_armed = 2'b10,
    bk_undo  = 2'b11
  } bk_t;

  localparam int user_bytes = emu_bytes - emu_map_pkg::monitor_bytes;

  logic [6:0]                      ctrl_q;
  logic [emu_map_pkg::ev_width-1:0] stat_q;
  logic [emu_map_pkg::ev_width-1:0] mask_q;
  logic [emu_map_pkg::ev_width-1:0] ev;
  logic [15:0]                     step_q;
  emu_map_pkg::run_t               run_q;
  bk_t                             bk_q;
  logic [aw-1:0]                   bk_addr_q;
  logic [7:0]                      bk_save_q;
  logic [aw-1:0]                   fault_q;
  logic [11:0]                     rng_off;
  logic                            rng_rd;
  emu_map_pkg::attr_t              attr;
  logic                            valid_q;
  logic                            write_q;
  logic                            fetch_q;
  logic [aw-1:0]                   addr_q;
  logic                            acc_wr;
  logic                            acc_rd;
  logic                            is_range;
  logic [31:0]                     tbl_rd;
  logic                            break_ev;

  // Decode of an APB offset into the range window
  function automatic logic in_range_win(input logic [11:0] a);
    return a >= emu_map_pkg::range_base &&
           a < emu_map_pkg::range_base +
               12'(emu_map_pkg::range_count << emu_map_pkg::range_stride_lg);
  endfunction : in_range_win

  // Attribute classes, shared by the event and select logic
  function automatic logic is_emu(input emu_map_pkg::attr_t t);
    return t == emu_map_pkg::attr_emu_ram || t == emu_map_pkg::attr_emu_rom;
  endfunction : is_emu

  function automatic logic is_rom(input emu_map_pkg::attr_t t);
    return t == emu_map_pkg::attr_emu_rom || t == emu_map_pkg::attr_tgt_rom;
  endfunction : is_rom

  assign acc_wr   = psel && penable && pwrite;
  assign acc_rd   = psel && penable && !pwrite;
  assign is_range = in_range_win(paddr);
  // Index counted from the window base, so the lowest offset is entry 0
  assign rng_off  = paddr - emu_map_pkg::range_base;
  assign rng_rd   = psel && is_range && !pwrite;

  range_table #(.entries(emu_map_pkg::range_count), .aw(aw)) u_tbl (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (acc_wr && is_range),
    .wr_idx    (rng_off[7:4]),
    .wr_fld    (rng_off[3:2]),
    .wr_data   (pwdata),
    .rd_idx    (rng_off[7:4]),
    .rd_fld    (rng_off[3:2]),
    .rd_data   (tbl_rd),
    .look_addr (cpu_addr),
    .look_attr (attr)
  );

  // Align request with the registered lookup result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      valid_q <= 1'b0;
      write_q <= 1'b0;
      fetch_q <= 1'b0;
      addr_q  <= '0;
    end
    else
    begin
      valid_q <= cpu_valid;
      write_q <= cpu_write;
      fetch_q <= cpu_fetch;
      addr_q  <= cpu_addr;
    end
  end

  // Events seen on the classified access, the analyzer trigger and the step count
  always_comb
  begin
    ev = '0;
    ev[emu_map_pkg::ev_guard] = valid_q && attr == emu_map_pkg::attr_guard;
    ev[emu_map_pkg::ev_rom]   = valid_q && write_q && ctrl_q[emu_map_pkg::ctrl_rom_brk_bit] &&
                                is_rom(attr);
    ev[emu_map_pkg::ev_trig]  = trig_in && ctrl_q[emu_map_pkg::ctrl_trig_brk_bit];
    ev[emu_map_pkg::ev_bkpt]  = valid_q && fetch_q && bk_q == bk_armed &&
                                addr_q == bk_addr_q;
    ev[emu_map_pkg::ev_step]  = run_q == emu_map_pkg::run_step && cpu_done &&
                                step_q == 16'h0001;
  end

  assign break_ev = |ev[emu_map_pkg::ev_step:emu_map_pkg::ev_rom];

  // Control register and step count; step and run commands are APB writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= emu_map_pkg::ctrl_reset_val;
      step_q <= '0;
      run_q  <= emu_map_pkg::run_bg;
    end
    else
    begin
      if (acc_wr && paddr == emu_map_pkg::ctrl_off)
      begin
        ctrl_q <= pwdata[6:0];
        run_q  <= pwdata[emu_map_pkg::ctrl_bg_bit] ? emu_map_pkg::run_bg : emu_map_pkg::run_fg;
      end
      else if (acc_wr && paddr == emu_map_pkg::step_off && pwdata[15:0] != 16'h0000)
      begin
        step_q <= pwdata[15:0];
        run_q  <= emu_map_pkg::run_step;
        ctrl_q[emu_map_pkg::ctrl_bg_bit] <= 1'b0;
      end
      else if (break_ev)
      begin
        run_q  <= emu_map_pkg::run_bg;
        ctrl_q[emu_map_pkg::ctrl_bg_bit] <= 1'b1;
        step_q <= '0;
      end
      else if (run_q == emu_map_pkg::run_step && cpu_done)
        step_q <= step_q - 16'h0001;
    end
  end

  // Sticky status; an event beats the read that clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= '0;
    else if (acc_rd && paddr == emu_map_pkg::irq_stat_off)
      stat_q <= ev;
    else
      stat_q <= stat_q | ev;
  end

  // Mask and fault address capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q  <= '0;
      fault_q <= '0;
    end
    else
    begin
      if (acc_wr && paddr == emu_map_pkg::irq_mask_off)
        mask_q <= pwdata[emu_map_pkg::ev_width-1:0];
      if (ev[emu_map_pkg::ev_guard] || ev[emu_map_pkg::ev_rom])
        fault_q <= addr_q;
    end
  end

  // Software breakpoint: read original byte, plant F1, restore after the hit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bk_q       <= bk_idle;
      bk_addr_q  <= '0;
      bk_save_q  <= '0;
      patch_we   <= 1'b0;
      patch_addr <= '0;
      patch_data <= '0;
    end
    else
    begin
      patch_we <= 1'b0;
      case (bk_q)
        bk_idle:
          if (acc_wr && paddr == emu_map_pkg::bkpt_addr_off)
          begin
            bk_addr_q  <= pwdata[aw-1:0];
            patch_addr <= pwdata[aw-1:0];
            bk_q       <= bk_read;
          end
        bk_read:
        begin
          bk_save_q  <= cpu_rdata;
          patch_data <= emu_map_pkg::bkpt_opcode;
          patch_we   <= 1'b1;
          bk_q       <= bk_armed;
        end
        bk_armed:
          if (ev[emu_map_pkg::ev_bkpt] ||
              (acc_wr && paddr == emu_map_pkg::bkpt_cmd_off && pwdata[0]))
            bk_q <= bk_undo;
        bk_undo:
        begin
          patch_data <= bk_save_q;
          patch_we   <= 1'b1;
          bk_q       <= bk_idle;
        end
        default: bk_q <= bk_idle;
      endcase
    end
  end

  // Processor-side outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_stall      <= 1'b0;
      cpu_break      <= 1'b0;
      cpu_reset      <= 1'b1;
      clk_sel_target <= 1'b0;
      tgt_cycle      <= 1'b0;
      emu_sel        <= 1'b0;
      rom_sel        <= 1'b0;
      irq            <= 1'b0;
    end
    else
    begin
      cpu_reset      <= ctrl_q[emu_map_pkg::ctrl_reset_bit] || tgt_reset;
      clk_sel_target <= ctrl_q[emu_map_pkg::ctrl_tclk_bit];
      emu_sel        <= valid_q && is_emu(attr);
      rom_sel        <= valid_q && is_rom(attr);
      // Background cycles reach the target only when shown
      tgt_cycle      <= valid_q && (run_q != emu_map_pkg::run_bg ||
                                    ctrl_q[emu_map_pkg::ctrl_show_bg_bit]);
      // Target wait on emulation memory only when honoured
      cpu_stall      <= tgt_wait && (!is_emu(attr) ||
                                     ctrl_q[emu_map_pkg::ctrl_wait_bit]);
      cpu_break      <= break_ev || run_q == emu_map_pkg::run_bg;
      irq            <= |(stat_q & mask_q);
    end
  end

  // Ready pulses one cycle; range-window reads wait one cycle more because the
  // table hands back its read data from a register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else if (pready)
      pready <= 1'b0;
    else if (rng_rd)
      pready <= penable;
    else
      pready <= psel && !penable;
  end

  // APB data; unmapped offsets read zero with pslverr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= 1'b0;
      prdata  <= '0;
      if (rng_rd && penable && !pready)
        prdata <= tbl_rd; // Table word registered at the setup edge
      if (psel && !penable)
      begin
        case (paddr)
          emu_map_pkg::ctrl_off:      prdata <= {25'h0, ctrl_q};
          emu_map_pkg::status_off:    prdata <= {28'h0, bk_q, run_q};
          emu_map_pkg::irq_stat_off:  prdata <= {27'h0, stat_q | ev};
          emu_map_pkg::irq_mask_off:  prdata <= {27'h0, mask_q};
          emu_map_pkg::step_off:      prdata <= {16'h0, step_q};
          emu_map_pkg::bkpt_addr_off: prdata <= 32'(bk_addr_q);
          emu_map_pkg::bkpt_cmd_off:  prdata <= 32'(user_bytes);
          emu_map_pkg::fault_off:     prdata <= 32'(fault_q);
          default:
            if (!is_range)
              pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : emu_map_ctrl

// *** emu_map_ctrl_props.sv ***
`timescale 1ns/1ps
module emu_map_ctrl_props (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core and target
  input wire logic        cpu_break,
  input wire logic        cpu_reset,
  input wire logic        clk_sel_target,
  input wire logic        tgt_cycle,
  input wire logic        tgt_reset,
  input wire logic        trig_in
);
  logic [6:0] ctrl_q;
  logic       in_win;
  // Range-window offsets; their reads carry one wait state
  assign in_win = paddr >= emu_map_pkg::range_base &&
                  paddr < emu_map_pkg::range_base +
                          12'(emu_map_pkg::range_count << emu_map_pkg::range_stride_lg);
  // Shadow of the control word; misses internal run/break changes of bit 6
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_q <= emu_map_pkg::ctrl_reset_val;
    else if (psel && penable && pready && pwrite && paddr == emu_map_pkg::ctrl_off)
      ctrl_q <= pwdata[6:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_answer: assert property (psel && !penable && (pwrite || !in_win) |=> pready)
    else $error("no ready one cycle after setup");
  a_range_wait: assert property (psel && !penable && !pwrite && in_win |=> !pready ##1 pready)
    else $error("range read ready not after one wait state");
  a_ready_phase: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside a single access cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");
  a_trig_break: assert property (trig_in && ctrl_q[1] |-> ##[1:3] cpu_break)
    else $error("trigger did not break");
  a_target_reset: assert property (tgt_reset |=> cpu_reset)
    else $error("target reset not passed to core");
  a_cmd_reset: assert property (ctrl_q[4] |-> ##[1:2] cpu_reset)
    else $error("commanded reset missing");
  a_clock_select: assert property ($changed(ctrl_q[5]) |-> ##[0:2] clk_sel_target == ctrl_q[5])
    else $error("clock select does not follow control");
  a_bg_hidden: assert property ((cpu_break && !ctrl_q[3]) [*4] |-> !tgt_cycle)
    else $error("background cycle shown to target");
endmodule : emu_map_ctrl_props
bind emu_map_ctrl emu_map_ctrl_props emu_map_ctrl_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .cpu_break(cpu_break), .cpu_reset(cpu_reset), .clk_sel_target(clk_sel_target),
  .tgt_cycle(tgt_cycle), .tgt_reset(tgt_reset), .trig_in(trig_in));

// *** target_board.sv ***
`timescale 1ns/1ps
// Target board behind the probe: wait requests and board reset
module target_board (
  // Clock and board controls
  input  wire logic pclk,
  input  wire logic slow,
  input  wire logic rst_req,
  // Probe side
  output logic      tgt_wait,
  output logic      tgt_reset
);
  // A slow board asks for wait on every cycle, emulation ones included
  always_ff @(posedge pclk)
    tgt_wait <= slow;
  // Board reset is a level, synchronous to the board clock
  always_ff @(posedge pclk)
    tgt_reset <= rst_req;
endmodule : target_board

// *** emu_map_ctrl_tb.sv ***
`timescale 1ns/1ps
module emu_map_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, e;
  logic        cpu_valid, cpu_write, cpu_fetch, cpu_done, cpu_stall, cpu_break;
  logic        cpu_reset, clk_sel_target, patch_we, tgt_wait, tgt_reset, tgt_cycle;
  logic        emu_sel, rom_sel, trig_in, irq, slow, rst_req;
  logic [23:0] cpu_addr, patch_addr;
  logic [7:0]  cpu_rdata, patch_data, orig;
  int          fail_count, samples_checked, cycles, stat_m, mask_m, i;
  integer      seed;
  logic [31:0] patch_q[$];
  emu_map_ctrl #(.aw(24), .emu_bytes(131072)) emu_map_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_valid(cpu_valid), .cpu_write(cpu_write), .cpu_fetch(cpu_fetch),
    .cpu_done(cpu_done), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata),
    .cpu_stall(cpu_stall), .cpu_break(cpu_break), .cpu_reset(cpu_reset),
    .clk_sel_target(clk_sel_target), .patch_we(patch_we), .patch_addr(patch_addr),
    .patch_data(patch_data), .tgt_wait(tgt_wait), .tgt_reset(tgt_reset),
    .tgt_cycle(tgt_cycle), .emu_sel(emu_sel), .rom_sel(rom_sel), .trig_in(trig_in),
    .irq(irq));
  target_board target_board_i (
    .pclk(pclk), .slow(slow), .rst_req(rst_req), .tgt_wait(tgt_wait),
    .tgt_reset(tgt_reset));
  // Free-running clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Log patch writes; a hang ends the run as a failure
  always @(posedge pclk)
  begin
    cycles++;
    if (patch_we === 1'b1)
      patch_q.push_back({patch_addr, patch_data});
    if (cycles == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    samples_checked++;
    if (s !== ex)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk
  // One APB transfer, held until ready, then released for a cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic set_rng(input int n, input logic [23:0] b, input logic [31:0] at);
    apb(1'b1, emu_map_pkg::range_base + 12'(n * 16), {8'h00, b});
    apb(1'b1, emu_map_pkg::range_base + 12'(n * 16 + 4), {8'h00, b | 24'h0000ff});
    apb(1'b1, emu_map_pkg::range_base + 12'(n * 16 + 8), at);
  endtask : set_rng
  // Processor access held three cycles, then one idle edge before outputs are read
  task automatic cpu(input logic [23:0] a, input logic w, input logic f);
    cpu_valid <= 1'b1;
    cpu_write <= w;
    cpu_fetch <= f;
    cpu_addr  <= a;
    repeat (3) @(posedge pclk);
    cpu_valid <= 1'b0;
    cpu_write <= 1'b0;
    cpu_fetch <= 1'b0;
    @(posedge pclk);
  endtask : cpu
  task automatic brk_chk(input logic ex);
    int n;
    for (n = 0; n < 8 && cpu_break !== ex; n++)
      @(posedge pclk);
    chk("cpu_break", ex, cpu_break);
  endtask : brk_chk
  task automatic irq_chk();
    repeat (3) @(posedge pclk);
    chk("irq", 32'((stat_m & mask_m) != 0), irq);
    apb(1'b0, emu_map_pkg::irq_stat_off, 32'h0);
    chk("irq_stat", stat_m, rd_v);
    stat_m = 0;
  endtask : irq_chk
  task automatic pulse_done();
    cpu_done <= 1'b1;
    @(posedge pclk);
    cpu_done <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse_done
  task automatic patch_chk(input logic [31:0] ex);
    repeat (4) @(posedge pclk);
    chk("patch", ex, patch_q.size() > 0 ? patch_q.pop_front() : 32'h0);
  endtask : patch_chk
  initial
  begin
    {presetn, psel, penable, pwrite, cpu_valid, cpu_write, cpu_fetch} = 7'h00;
    {cpu_done, trig_in, slow, rst_req} = 4'h0;
    {paddr, pwdata, cpu_addr, cpu_rdata} = 76'h0;
    {fail_count, samples_checked, cycles, stat_m, mask_m} = 160'h0;
    seed = 32'h8e2633e6;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("cpu_reset", 32'h0, cpu_reset);
    apb(1'b0, emu_map_pkg::ctrl_off, 32'h0);
    chk("ctrl", 32'h40, rd_v);
    apb(1'b0, emu_map_pkg::bkpt_cmd_off, 32'h0);
    chk("emu_free", 32'd131072 - 32'd4096, rd_v);
    apb(1'b0, 12'h020, 32'h0);
    chk("pslverr", 32'h1, err_v);
    // Every entry, every attribute code, random page bases
    for (i = 0; i < 16; i++)
    begin
      e = $random(seed) & 32'h00ffff00;
      set_rng(i, e[23:0], 32'(i % 6));
      apb(1'b0, emu_map_pkg::range_base + 12'(i * 16), 32'h0);
      chk("range_base", e, rd_v);
      apb(1'b0, emu_map_pkg::range_base + 12'(i * 16 + 8), 32'h0);
      chk("range_attr", 32'(i % 6), rd_v);
      apb(1'b1, emu_map_pkg::range_base + 12'(i * 16 + 8), 32'h0);
    end
    set_rng(0, 24'h001000, 32'h5);
    set_rng(1, 24'h002000, 32'h2);
    set_rng(2, 24'h003000, 32'h1);
    set_rng(3, 24'h004000, 32'h4);
    mask_m = 32'h1f;
    apb(1'b1, emu_map_pkg::irq_mask_off, 32'h1f);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h2);
    cpu(24'h0010ff, 1'b0, 1'b0);
    stat_m |= 1 << emu_map_pkg::ev_guard;
    irq_chk();
    cpu(24'h001100, 1'b0, 1'b0);
    chk("tgt_cycle", 32'h1, tgt_cycle);
    chk("emu_sel", 32'h0, emu_sel);
    cpu(24'h003000, 1'b0, 1'b0);
    chk("emu_sel", 32'h1, emu_sel);
    chk("rom_sel", 32'h0, rom_sel);
    cpu(24'h002000, 1'b1, 1'b0);
    chk("rom_sel", 32'h1, rom_sel);
    brk_chk(1'b0);
    apb(1'b0, emu_map_pkg::irq_stat_off, 32'h0);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h3);
    cpu(24'h004010, 1'b1, 1'b0);
    brk_chk(1'b1);
    stat_m |= 1 << emu_map_pkg::ev_rom;
    irq_chk();
    apb(1'b0, emu_map_pkg::fault_off, 32'h0);
    chk("fault", 32'h004010, rd_v);
    // Emulation cycle under a waiting board, wait ignored then honoured
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h0);
    slow <= 1'b1;
    cpu(24'h003000, 1'b0, 1'b0);
    chk("cpu_stall", 32'h0, cpu_stall);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h4);
    cpu(24'h003000, 1'b0, 1'b0);
    chk("cpu_stall", 32'h1, cpu_stall);
    slow <= 1'b0;
    // Trigger break with the interrupt masked, then unmasked
    mask_m = 0;
    apb(1'b1, emu_map_pkg::irq_mask_off, 32'h0);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h2);
    trig_in <= 1'b1;
    @(posedge pclk);
    trig_in <= 1'b0;
    brk_chk(1'b1);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h0, irq);
    mask_m = 32'h1f;
    apb(1'b1, emu_map_pkg::irq_mask_off, 32'h1f);
    stat_m |= 1 << emu_map_pkg::ev_trig;
    irq_chk();
    irq_chk();
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h40);
    cpu(24'h001100, 1'b0, 1'b0);
    chk("tgt_cycle", 32'h0, tgt_cycle);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h48);
    cpu(24'h001100, 1'b0, 1'b0);
    chk("tgt_cycle", 32'h1, tgt_cycle);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h40);
    apb(1'b1, emu_map_pkg::step_off, 32'h2);
    brk_chk(1'b0);
    pulse_done();
    chk("cpu_break", 32'h0, cpu_break);
    pulse_done();
    brk_chk(1'b1);
    stat_m |= 1 << emu_map_pkg::ev_step;
    irq_chk();
    // Breakpoint patch, hit and restore
    orig = 8'($random(seed));
    cpu_rdata <= orig;
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h0);
    apb(1'b1, emu_map_pkg::bkpt_addr_off, 32'h003040);
    patch_chk({24'h003040, emu_map_pkg::bkpt_opcode});
    cpu_rdata <= emu_map_pkg::bkpt_opcode;
    cpu(24'h003040, 1'b0, 1'b1);
    brk_chk(1'b1);
    patch_chk({24'h003040, orig});
    stat_m |= 1 << emu_map_pkg::ev_bkpt;
    irq_chk();
    // Breakpoint removed by command restores the saved byte
    cpu_rdata <= orig;
    apb(1'b1, emu_map_pkg::bkpt_addr_off, 32'h003080);
    patch_chk({24'h003080, emu_map_pkg::bkpt_opcode});
    apb(1'b1, emu_map_pkg::bkpt_cmd_off, 32'h1);
    patch_chk({24'h003080, orig});
    rst_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("cpu_reset", 32'h1, cpu_reset);
    rst_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("cpu_reset", 32'h0, cpu_reset);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h10);
    repeat (2) @(posedge pclk);
    chk("cpu_reset", 32'h1, cpu_reset);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h60);
    repeat (2) @(posedge pclk);
    chk("clk_sel", 32'h1, clk_sel_target);
    apb(1'b1, emu_map_pkg::ctrl_off, 32'h40);
    repeat (2) @(posedge pclk);
    chk("clk_sel", 32'h0, clk_sel_target);
    end_sim();
  end
endmodule : emu_map_ctrl_tb
